// *** verilog/progmem_defines.svh ***
// How it works
// - program memory is 16 bits wide with 8K, 16K or 32K words held as one, two or four 8K banks.
// - table data may sit anywhere and is reached through a table pointer kept apart from the fetch counter.
// - after reset, instruction fetch starts at word zero, the reset vector.
// - the table address is the low seven bits of the high pointer byte above the low pointer byte.
// - a table read writes the low byte of the word to the data register named by the operand.
// - the same table read loads the high byte of the word into the high byte latch.
// - the normal read targets data sector 0 and the extended read targets the sector named by the operand, sector 0 included.
// - for the normal read the low pointer is an offset into the page chosen by the high pointer.
// - every table instruction takes two instruction cycles.
// - software can read and write the high byte latch so it can be saved and restored.
// - one instruction cycle is four phases of the system clock, so a table read lasts eight clocks.
`ifndef PROGMEM_DEFINES_SVH
`define PROGMEM_DEFINES_SVH
`define WORD_W 16
`define BANK_AW 13
`define MAX_AW 15
`define RESET_VECTOR 15'h0000
`define PHASES 2'h3
`define TABLE_CYCLES 1'h1
`define READ_CLKS 4'h8
`define NORMAL_SECTOR 3'h0
`define SECTOR_W 3
`define DADDR_W 8
`endif

// *** verilog/progmem_pkg.sv ***
package progmem_pkg;
   typedef enum logic [2:0] {
      st_idle = 3'b001,
      st_read = 3'b010,
      st_done = 3'b100
   } table_state_e;
endpackage

// *** verilog/phase_if.sv ***
`timescale 1ns/1ps
interface phase_if;
   logic [1:0] phase;
   logic cycle_end;
   modport gen (output phase, output cycle_end);
   modport use_side (input phase, input cycle_end);
endinterface

// *** verilog/phase_gen.sv ***
`timescale 1ns/1ps
`include "progmem_defines.svh"
module phase_gen (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // phase outputs
   phase_if.gen ph
);
   logic [1:0] cnt;
   logic [1:0] next_cnt;
   always_comb begin
      next_cnt = cnt + 2'h1;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 2'h0;
      end else begin
         cnt <= next_cnt;
      end
   end
   assign ph.phase = cnt;
   assign ph.cycle_end = (cnt == `PHASES);
   phase_wrap_a: assert property (@(posedge clk) disable iff (rst)
      ph.cycle_end |=> ph.phase == 2'h0) else $error("phase did not wrap");
endmodule // phase_gen

// *** verilog/progmem_store.sv ***
`timescale 1ns/1ps
`include "progmem_defines.svh"
module progmem_store #(
   parameter int BANKS = 4
) (
   // clock
   input wire logic clk,
   // write port for loading contents
   input wire logic we,
   input wire logic [`MAX_AW-1:0] waddr,
   input wire logic [`WORD_W-1:0] wdata,
   // two read ports
   input wire logic [`MAX_AW-1:0] addr_a,
   output logic [`WORD_W-1:0] data_a,
   input wire logic [`MAX_AW-1:0] addr_b,
   output logic [`WORD_W-1:0] data_b
);
   localparam int DEPTH = BANKS << `BANK_AW;
   logic [`WORD_W-1:0] mem [DEPTH];
   // one write process; contents loaded by the programming side
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr[$clog2(DEPTH)-1:0]] <= wdata;
      end
   end
   // address bits above capacity dropped
   always_ff @(posedge clk) begin
      data_a <= mem[addr_a[$clog2(DEPTH)-1:0]];
      data_b <= mem[addr_b[$clog2(DEPTH)-1:0]];
   end
endmodule // progmem_store

// *** verilog/program_memory_table_read.sv ***
`timescale 1ns/1ps
`include "progmem_defines.svh"
module program_memory_table_read
   import progmem_pkg::*;
#(
   parameter int BANKS = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // fetch side
   input wire logic [`MAX_AW-1:0] pc,
   input wire logic pc_load,
   output logic [`WORD_W-1:0] instr,
   output logic [`MAX_AW-1:0] fetch_addr,
   // table pointer and latch access
   input wire logic [7:0] ptr_low,
   input wire logic [7:0] ptr_high,
   input wire logic latch_we,
   input wire logic [7:0] latch_wdata,
   output logic [7:0] table_high_byte_latch,
   // table read request
   input wire logic table_start,
   input wire logic extended_table_read_op,
   input wire logic [`SECTOR_W-1:0] dest_sector,
   input wire logic [`DADDR_W-1:0] dest_addr,
   // data memory write
   output logic dm_we,
   output logic [`SECTOR_W-1:0] dm_sector,
   output logic [`DADDR_W-1:0] dm_addr,
   output logic [7:0] dm_data,
   output logic table_busy,
   // content loading
   input wire logic prog_we,
   input wire logic [`MAX_AW-1:0] prog_addr,
   input wire logic [`WORD_W-1:0] prog_data
);
   localparam int AW = $clog2(BANKS) + `BANK_AW;

   phase_if ph ();
   phase_gen u_phase (
      .clk(clk),
      .rst(rst),
      .ph(ph)
   );

   // mask pointer bits beyond the fitted capacity
   function automatic logic [`MAX_AW-1:0] table_addr(input logic [7:0] hi, input logic [7:0] lo);
      logic [`MAX_AW:0] full;
      full = {1'b0, hi[6:0], lo};
      table_addr = full[`MAX_AW-1:0] & `MAX_AW'((1 << AW) - 1);
   endfunction

   logic [`MAX_AW-1:0] taddr;
   logic [`WORD_W-1:0] tdata;
   logic [`WORD_W-1:0] idata;

   progmem_store #(.BANKS(BANKS)) u_store (
      .clk(clk),
      .we(prog_we),
      .waddr(prog_addr),
      .wdata(prog_data),
      .addr_a(fetch_addr),
      .data_a(idata),
      .addr_b(taddr),
      .data_b(tdata)
   );

   // fetch counter is separate from the table pointer
   logic [`MAX_AW-1:0] next_fetch_addr;
   logic [`WORD_W-1:0] next_instr;
   always_comb begin
      next_fetch_addr = fetch_addr;
      next_instr = instr;
      if (pc_load) begin
         next_fetch_addr = pc;
      end
      if (ph.cycle_end) begin
         next_instr = idata;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fetch_addr <= `RESET_VECTOR;
         instr <= `WORD_W'h0000;
      end else begin
         fetch_addr <= next_fetch_addr;
         instr <= next_instr;
      end
   end

   // table read sequencer, two instruction cycles per read
   table_state_e state;
   table_state_e next_state;
   logic cyc;
   logic next_cyc;
   logic ext;
   logic next_ext;
   logic [`SECTOR_W-1:0] next_dm_sector;
   logic [`DADDR_W-1:0] next_dm_addr;
   logic [7:0] next_dm_data;
   logic next_dm_we;
   logic [7:0] next_latch;
   logic next_busy;
   logic [`MAX_AW-1:0] next_taddr;
   logic read_last;

   // last phase of the second instruction cycle
   assign read_last = (state == st_read) && ph.cycle_end && (cyc == `TABLE_CYCLES);

   always_comb begin
      next_state = state;
      next_cyc = cyc;
      next_ext = ext;
      next_dm_sector = dm_sector;
      next_dm_addr = dm_addr;
      next_dm_data = dm_data;
      next_dm_we = 1'b0;
      next_latch = table_high_byte_latch;
      next_busy = table_busy;
      next_taddr = taddr;
      if (latch_we) begin
         next_latch = latch_wdata;
      end
      case (state)
         st_idle: begin
            if (table_start && ph.cycle_end) begin
               next_state = st_read;
               next_cyc = 1'b0;
               next_busy = 1'b1;
               next_taddr = table_addr(ptr_high, ptr_low);
               next_ext = extended_table_read_op;
               // normal read always lands in sector 0
               next_dm_sector = extended_table_read_op ? dest_sector : `NORMAL_SECTOR;
               next_dm_addr = dest_addr;
            end
         end
         st_read: begin
            if (read_last) begin
               // result lands on the eighth clock, so busy spans exactly eight
               next_state = st_done;
               next_dm_we = 1'b1;
               next_dm_data = tdata[7:0];
               next_latch = tdata[15:8];
               next_busy = 1'b0;
            end else if (ph.cycle_end) begin
               next_cyc = 1'b1;
            end
         end
         st_done: begin
            // one idle clock; the next take needs a cycle end anyway
            next_state = st_idle;
         end
         default: begin
            next_state = st_idle;
            next_busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= st_idle;
         cyc <= 1'b0;
         ext <= 1'b0;
         dm_sector <= `NORMAL_SECTOR;
         dm_addr <= `DADDR_W'h00;
         dm_data <= 8'h00;
         dm_we <= 1'b0;
         table_high_byte_latch <= 8'h00;
         table_busy <= 1'b0;
         taddr <= `RESET_VECTOR;
      end else begin
         state <= next_state;
         cyc <= next_cyc;
         ext <= next_ext;
         dm_sector <= next_dm_sector;
         dm_addr <= next_dm_addr;
         dm_data <= next_dm_data;
         dm_we <= next_dm_we;
         table_high_byte_latch <= next_latch;
         table_busy <= next_busy;
         taddr <= next_taddr;
      end
   end

   // one select per fitted bank; exactly one may be hit
   logic [BANKS-1:0] bank_hit;
   for (genvar b = 0; b < BANKS; b++) begin : g_bank
      assign bank_hit[b] = (taddr >> `BANK_AW) == `MAX_AW'(b);
   end

   // clocks spent in the current read, kept for the length checks
   logic [3:0] busy_clks;
   logic [3:0] next_busy_clks;
   always_comb begin
      next_busy_clks = 4'h0;
      if (next_busy) begin
         next_busy_clks = busy_clks + 4'h1;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_clks <= 4'h0;
      end else begin
         busy_clks <= next_busy_clks;
      end
   end

   // read spans eight clocks, the result lands as busy drops
   busy_len_a: assert property (@(posedge clk) disable iff (rst)
      $rose(table_busy) |-> table_busy [*8] ##1 !table_busy)
      else $error("read length wrong");

   dm_pulse_a: assert property (@(posedge clk) disable iff (rst)
      dm_we |-> $fell(table_busy))
      else $error("write not at read end");

   sector_zero_a: assert property (@(posedge clk) disable iff (rst)
      dm_we && !ext |-> dm_sector == `NORMAL_SECTOR)
      else $error("normal read left sector 0");

   latch_load_a: assert property (@(posedge clk) disable iff (rst)
      dm_we |-> table_high_byte_latch == $past(tdata[15:8]))
      else $error("latch not loaded");

   low_byte_a: assert property (@(posedge clk) disable iff (rst)
      dm_we |-> dm_data == $past(tdata[7:0]))
      else $error("low byte wrong");

   latch_write_a: assert property (@(posedge clk) disable iff (rst)
      latch_we && !read_last |=> table_high_byte_latch == $past(latch_wdata))
      else $error("latch write lost");

   addr_form_a: assert property (@(posedge clk) disable iff (rst)
      $rose(table_busy) |-> taddr == table_addr($past(ptr_high), $past(ptr_low)))
      else $error("table address wrong");

   addr_cap_a: assert property (@(posedge clk) disable iff (rst)
      (taddr >> AW) == 0)
      else $error("address above capacity");

   page_offset_a: assert property (@(posedge clk) disable iff (rst)
      $rose(table_busy) && !ext |->
         taddr == (table_addr($past(ptr_high), 8'h00) | `MAX_AW'($past(ptr_low))))
      else $error("offset not inside page");

   fetch_load_a: assert property (@(posedge clk) disable iff (rst)
      pc_load |=> fetch_addr == $past(pc))
      else $error("fetch address not loaded");

   fetch_hold_a: assert property (@(posedge clk) disable iff (rst)
      !pc_load |=> $stable(fetch_addr))
      else $error("fetch address moved");

   state_onehot_a: assert property (@(posedge clk) disable iff (rst)
      $onehot(state))
      else $error("sequencer state broken");

   dm_single_a: assert property (@(posedge clk) disable iff (rst)
      dm_we |=> !dm_we)
      else $error("result write too long");

   busy_take_a: assert property (@(posedge clk) disable iff (rst)
      $rose(table_busy) |-> $past(ph.cycle_end) && $past(table_start))
      else $error("read taken off phase");

   addr_hold_a: assert property (@(posedge clk) disable iff (rst)
      table_busy |=> $stable(taddr))
      else $error("address moved during read");

   dm_hold_a: assert property (@(posedge clk) disable iff (rst)
      !dm_we |-> $stable(dm_data))
      else $error("result changed without write");

   bank_one_a: assert property (@(posedge clk) disable iff (rst)
      $onehot(bank_hit))
      else $error("bank select broken");

   busy_count_a: assert property (@(posedge clk) disable iff (rst)
      dm_we |-> $past(busy_clks) == `READ_CLKS)
      else $error("read not eight clocks");

   count_cap_a: assert property (@(posedge clk) disable iff (rst)
      busy_clks <= `READ_CLKS)
      else $error("read overran");

   sector_ext_a: assert property (@(posedge clk) disable iff (rst)
      $rose(table_busy) && ext |-> dm_sector == $past(dest_sector))
      else $error("extended sector lost");

   latch_hold_a: assert property (@(posedge clk) disable iff (rst)
      !dm_we && !$past(latch_we) |-> $stable(table_high_byte_latch))
      else $error("latch changed by itself");

   done_idle_a: assert property (@(posedge clk) disable iff (rst)
      state == st_done |=> state == st_idle)
      else $error("done state held");

   take_cyc_a: assert property (@(posedge clk) disable iff (rst)
      $rose(table_busy) |-> state == st_read && cyc == 1'b0)
      else $error("read started mid count");
endmodule // program_memory_table_read

// *** verif/table_core_model.sv ***
`timescale 1ns/1ps
`include "progmem_defines.svh"
module table_core_model (
   // clock
   input wire logic clk,
   // request side
   output logic table_start,
   output logic extended_table_read_op,
   output logic [`SECTOR_W-1:0] dest_sector,
   output logic [`DADDR_W-1:0] dest_addr,
   output logic [7:0] ptr_low,
   output logic [7:0] ptr_high,
   // answer side
   input wire logic table_busy,
   input wire logic dm_we
);
   initial begin
      table_start = 1'b0;
      extended_table_read_op = 1'b0;
      dest_sector = 3'h0;
      dest_addr = 8'h00;
      ptr_low = 8'h00;
      ptr_high = 8'h00;
   end
   // holds the request until busy is seen, then scrambles the pointer
   task automatic read(input logic [7:0] hi, input logic [7:0] lo, input logic ext,
                       input logic [2:0] sec, input logic [7:0] da, output int waited);
      int n;
      @(negedge clk);
      ptr_high = hi;
      ptr_low = lo;
      extended_table_read_op = ext;
      dest_sector = sec;
      dest_addr = da;
      table_start = 1'b1;
      n = 0;
      while (table_busy !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      table_start = 1'b0;
      // sampled only at the take, so later values must not leak in
      ptr_high = ~hi;
      ptr_low = ~lo;
      dest_addr = ~da;
      waited = 0;
      // no new read until this one lands, so the latch is never overwritten
      while (dm_we !== 1'b1 && waited < 20) begin
         @(negedge clk);
         waited++;
      end
   endtask
endmodule // table_core_model

// *** verif/program_memory_table_read_tb.sv ***
`timescale 1ns/1ps
`include "progmem_defines.svh"
module program_memory_table_read_tb;
   typedef struct {logic [7:0] hi; logic [7:0] lo; logic ext; logic [2:0] sec;
                   logic [7:0] da;} row_s;
   logic clk = 1'b0, rst = 1'b1, latch_we = 1'b0, prog_we = 1'b0, table_start;
   logic pc_load = 1'b0;
   logic [14:0] pc = 15'h0000;
   logic extended_table_read_op, dm_we, table_busy;
   logic [7:0] ptr_low, ptr_high, latch_wdata = 8'h00, table_high_byte_latch, dm_data, dest_addr;
   logic [7:0] dm_addr;
   logic [2:0] dest_sector, dm_sector;
   logic [14:0] fetch_addr, prog_addr = 15'h0000, a;
   logic [15:0] instr, prog_data = 16'h0000, e;
   int bad_count = 0, checks = 0, w;
   row_s rows[6] = '{'{8'h7F, 8'h06, 1'b0, 3'h0, 8'h10}, '{8'h7F, 8'h05, 1'b0, 3'h5, 8'h11},
                     '{8'h00, 8'h00, 1'b1, 3'h1, 8'h20}, '{8'hFF, 8'hFF, 1'b1, 3'h7, 8'hFF},
                     '{8'h80, 8'h06, 1'b1, 3'h2, 8'h00}, '{8'h20, 8'h00, 1'b1, 3'h6, 8'h30}};
   always #50 clk = ~clk;
   program_memory_table_read uut (.clk(clk), .rst(rst), .pc(pc), .pc_load(pc_load),
      .instr(instr), .fetch_addr(fetch_addr), .ptr_low(ptr_low), .ptr_high(ptr_high),
      .latch_we(latch_we), .latch_wdata(latch_wdata),
      .table_high_byte_latch(table_high_byte_latch), .table_start(table_start),
      .extended_table_read_op(extended_table_read_op), .dest_sector(dest_sector),
      .dest_addr(dest_addr), .dm_we(dm_we), .dm_sector(dm_sector), .dm_addr(dm_addr),
      .dm_data(dm_data), .table_busy(table_busy), .prog_we(prog_we), .prog_addr(prog_addr),
      .prog_data(prog_data));
   table_core_model core (.clk(clk), .table_start(table_start),
      .extended_table_read_op(extended_table_read_op), .dest_sector(dest_sector),
      .dest_addr(dest_addr), .ptr_low(ptr_low), .ptr_high(ptr_high),
      .table_busy(table_busy), .dm_we(dm_we));
   // table content pattern; high byte differs from low so swaps show
   function automatic logic [15:0] word_at(input logic [14:0] ad);
      return {ad[14:7], ad[7:0] ^ 8'h3C};
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic run_row(input row_s r);
      core.read(r.hi, r.lo, r.ext, r.sec, r.da, w);
      a = {r.hi[6:0], r.lo};
      e = word_at(a);
      check(16'(w), 16'd8, "read length");
      check(16'(dm_data), 16'(e[7:0]), "low byte");
      check(16'(table_high_byte_latch), 16'(e[15:8]), "high latch");
      check(16'(dm_sector), r.ext ? 16'(r.sec) : 16'h0000, "sector");
      check(16'(dm_addr), 16'(r.da), "dest addr");
   endtask
   initial begin
      repeat (2) @(negedge clk);
      check(16'(fetch_addr), 16'h0000, "fetch in reset");
      rst = 1'b0;
      // words sit anywhere, reads come back to back
      for (int i = 0; i < 6; i++) begin
         @(negedge clk);
         prog_we = 1'b1;
         prog_addr = {rows[i].hi[6:0], rows[i].lo};
         prog_data = word_at(prog_addr);
      end
      @(negedge clk);
      prog_we = 1'b0;
      for (int i = 0; i < 6; i++) begin
         run_row(rows[i]);
         $display("row %0d done", i);
      end
      check(16'(fetch_addr), 16'h0000, "fetch kept");
      check(instr, word_at(15'h0000), "instr at vector");
      @(negedge clk);
      pc = 15'h7F06;
      pc_load = 1'b1;
      @(negedge clk);
      pc_load = 1'b0;
      check(16'(fetch_addr), 16'h7F06, "fetch load");
      // memory read plus up to one full instruction cycle
      repeat (6) @(negedge clk);
      check(instr, word_at(15'h7F06), "instr fetch");
      $display("fetch test done");
      @(negedge clk);
      latch_we = 1'b1;
      latch_wdata = 8'hC3;
      @(negedge clk);
      latch_we = 1'b0;
      check(16'(table_high_byte_latch), 16'h00C3, "latch write");
      $display("latch test done");
      // reset while a read is in flight must drop it cleanly
      fork
         core.read(8'h01, 8'h02, 1'b1, 3'h3, 8'h44, w);
      join_none
      repeat (8) @(negedge clk);
      rst = 1'b1;
      @(negedge clk);
      check(16'(table_busy), 16'h0000, "busy in reset");
      check(16'(dm_we), 16'h0000, "write in reset");
      check(instr, 16'h0000, "instr in reset");
      check(16'(table_high_byte_latch), 16'h0000, "latch in reset");
      check(16'(fetch_addr), 16'h0000, "fetch after reset");
      repeat (25) @(negedge clk);
      rst = 1'b0;
      run_row(rows[1]);
      $display("mid reset test done");
      report_and_stop();
   end
   initial begin
      repeat (2000) @(posedge clk);
      bad_count++;
      report_and_stop();
   end
endmodule // program_memory_table_read_tb
